// [logic/tsg_sound.sv]
`include "tsg_defines.svh"

// Overview of operation
// - Source select picks LF, LF/2, HF, HF/16
// - Channel one: 7-bit divider, octave 1 or 1/8
// - Channel one runs only while enabled
// - Channel two: 7-bit divider, 15-bit noise, enable, octave
// - Channel two gives noise or tone; alarm envelope gates channel one
// - Function bits choose tone, noise or alarm
// - Mixer joins channels, then volume control
// - Route bits hand pins to sound, inverted
// - Volume codes 00..11 give levels 1..4
// - Codes follow pseudo-random sequence to N
// - Source 00 forces volume level four
// - Half period is N scaled tone clocks
// - Alarm bits pick 1/4/8/32 Hz envelopes
module tsg_sound
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Oscillator pins
	input wire logic low_frequency_source,
	input wire logic high_frequency_source,
	// System register port
	input wire logic [4:0] sys_addr,
	input wire logic sys_wr,
	input wire logic sys_rd,
	input wire logic [3:0] sys_wdata,
	output logic [3:0] sys_rdata,
	// Port A sharing and port mode
	output tsg_pkg::tsg_pins_t pins,
	output tsg_pkg::tsg_port_mode_control_t port_mode
);

	function automatic logic [6:0] step7(input logic [6:0] s);
		step7 = {s[5:0], s[6] ^ s[5]};
	endfunction

	function automatic logic scaled(input logic oct, input logic [2:0] pre);
		scaled = !oct || (pre == `TSG_OCT_LAST);
	endfunction

	//==========================================
	// Oscillator synchronisers
	logic lf_s1_reg, lf_s2_reg, lf_s3_reg;
	logic hf_s1_reg, hf_s2_reg, hf_s3_reg;
	logic lf_edge, hf_edge;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			lf_s1_reg <= 1'b0;
			lf_s2_reg <= 1'b0;
			lf_s3_reg <= 1'b0;
			hf_s1_reg <= 1'b0;
			hf_s2_reg <= 1'b0;
			hf_s3_reg <= 1'b0;
		end
		else
		begin
			lf_s1_reg <= low_frequency_source;
			lf_s2_reg <= lf_s1_reg;
			lf_s3_reg <= lf_s2_reg;
			hf_s1_reg <= high_frequency_source;
			hf_s2_reg <= hf_s1_reg;
			hf_s3_reg <= hf_s2_reg;
		end
	end

	// Each oscillator must stay below a quarter of mclk
	assign lf_edge = lf_s2_reg && !lf_s3_reg;
	assign hf_edge = hf_s2_reg && !hf_s3_reg;

	//==========================================
	// Registers
	tsg_pkg::tsg_mode_t mode_reg;
	tsg_pkg::tsg_ctl_t ctl_reg;
	tsg_pkg::tsg_port_mode_control_t port_mode_control_reg;
	logic [6:0] code1_reg;
	logic first_channel_octave_reg;
	logic [14:0] code2_reg;
	logic second_channel_octave_reg;
	logic [3:0] env_bits;
	logic wr_ok;

	assign wr_ok = sys_wr;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_reg <= `TSG_RST_NIB;
			ctl_reg <= `TSG_RST_NIB;
			port_mode_control_reg <= `TSG_RST_NIB;
		end
		else if (wr_ok)
		begin
			if (sys_addr == `TSG_A_PORT_MODE_CONTROL)
				port_mode_control_reg <= sys_wdata;
			else if (sys_addr == `TSG_A_CTL)
				ctl_reg <= sys_wdata;
			else if (sys_addr == `TSG_A_MODE)
				mode_reg <= sys_wdata;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			code1_reg <= `TSG_RST_CODE;
			first_channel_octave_reg <= 1'b0;
			code2_reg <= 15'h0000;
			second_channel_octave_reg <= 1'b0;
		end
		else if (wr_ok)
		begin
			if (sys_addr == `TSG_A_C1L)
				code1_reg[3:0] <= sys_wdata;
			else if (sys_addr == `TSG_A_C1H)
			begin
				code1_reg[6:4] <= sys_wdata[2:0];
				first_channel_octave_reg <= sys_wdata[3];
			end
			else if (sys_addr == `TSG_A_C2N1)
				code2_reg[3:0] <= sys_wdata;
			else if (sys_addr == `TSG_A_C2N2)
				code2_reg[7:4] <= sys_wdata;
			else if (sys_addr == `TSG_A_C2N3)
				code2_reg[11:8] <= sys_wdata;
			else if (sys_addr == `TSG_A_C2N4)
			begin
				code2_reg[14:12] <= sys_wdata[2:0];
				second_channel_octave_reg <= sys_wdata[3];
			end
		end
	end

	// Only $13 reads back; $19 returns the envelope bits, in alarm mode only; the rest are write only
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			sys_rdata <= 4'h0;
		else if (sys_rd)
		begin
			if (sys_addr == `TSG_A_PORT_MODE_CONTROL)
				sys_rdata <= port_mode_control_reg;
			else if (sys_addr == `TSG_A_C2N1 && mode_reg.alarm_function_bit)
				sys_rdata <= env_bits;
			else
				sys_rdata <= 4'h0;
		end
	end

	assign port_mode = port_mode_control_reg;

	//==========================================
	// Tone clock multiplexer
	logic lf_half_reg;
	logic [3:0] hf_cnt_reg;
	logic tone_tick;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			lf_half_reg <= 1'b0;
			hf_cnt_reg <= 4'h0;
		end
		else
		begin
			if (lf_edge)
				lf_half_reg <= !lf_half_reg;
			if (hf_edge)
				hf_cnt_reg <= hf_cnt_reg + 4'h1;
		end
	end

	always_comb
	begin
		case (mode_reg.clk_sel)
			`TSG_SRC_LF: tone_tick = lf_edge;
			`TSG_SRC_LF2: tone_tick = lf_edge && lf_half_reg;
			`TSG_SRC_HF: tone_tick = hf_edge;
			default: tone_tick = hf_edge && (hf_cnt_reg == `TSG_HF_LAST);
		endcase
	end

	//==========================================
	// Channel one
	logic [2:0] pre1_reg;
	logic [6:0] ch1_lfsr_reg;
	logic first_channel_output_reg;
	logic ch1_tick;
	logic en1, en2, alarm;

	assign en1 = ctl_reg.first_channel_enable;
	assign en2 = ctl_reg.second_channel_enable;
	assign alarm = mode_reg.alarm_function_bit;
	assign ch1_tick = tone_tick && en1 && scaled(first_channel_octave_reg, pre1_reg);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			pre1_reg <= 3'h0;
		else if (tone_tick && en1)
			pre1_reg <= pre1_reg + 3'h1;
	end

	// A zero code never reaches the last state, so the channel stays silent
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ch1_lfsr_reg <= `TSG_RST_CODE;
			first_channel_output_reg <= 1'b0;
		end
		else if (ch1_tick)
		begin
			if (ch1_lfsr_reg == `TSG_CODE_LAST)
			begin
				ch1_lfsr_reg <= code1_reg;
				first_channel_output_reg <= !first_channel_output_reg;
			end
			else if (ch1_lfsr_reg == 7'h00)
				ch1_lfsr_reg <= code1_reg;
			else
				ch1_lfsr_reg <= step7(ch1_lfsr_reg);
		end
	end

	//==========================================
	// Channel two
	logic [2:0] pre2_reg;
	logic [6:0] ch2_lfsr_reg;
	logic [14:0] noise_reg;
	logic ch2_tone_reg;
	logic ch2_tick;
	logic second_channel_output;

	assign ch2_tick = tone_tick && en2 && scaled(second_channel_octave_reg, pre2_reg);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			pre2_reg <= 3'h0;
		else if (tone_tick && en2)
			pre2_reg <= pre2_reg + 3'h1;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ch2_lfsr_reg <= `TSG_RST_CODE;
			ch2_tone_reg <= 1'b0;
		end
		else if (ch2_tick && !alarm)
		begin
			if (ch2_lfsr_reg == `TSG_CODE_LAST)
			begin
				ch2_lfsr_reg <= code2_reg[14:8];
				ch2_tone_reg <= !ch2_tone_reg;
			end
			else if (ch2_lfsr_reg == 7'h00)
				ch2_lfsr_reg <= code2_reg[14:8];
			else
				ch2_lfsr_reg <= step7(ch2_lfsr_reg);
		end
	end

	// Seeded non-zero so the noise sequence can never lock up
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			noise_reg <= `TSG_NOISE_SEED;
		else if (ch2_tick && mode_reg.noise_function_bit && !alarm)
			noise_reg <= {noise_reg[13:0], noise_reg[14] ^ noise_reg[13]};
	end

	assign second_channel_output = mode_reg.noise_function_bit ? noise_reg[14] : ch2_tone_reg;

	//==========================================
	// Alarm envelope
	logic [14:0] env_cnt_reg;
	logic envelope;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			env_cnt_reg <= 15'h0000;
		else if (lf_edge)
			env_cnt_reg <= env_cnt_reg + 15'h0001;
	end

	assign env_bits = {env_cnt_reg[`TSG_ENV_32HZ], env_cnt_reg[`TSG_ENV_8HZ],
		env_cnt_reg[`TSG_ENV_4HZ], env_cnt_reg[`TSG_ENV_1HZ]};
	assign envelope = (code2_reg[3:0] == 4'h0) || |(code2_reg[3:0] & env_bits);

	//==========================================
	// Mixer and volume
	logic mix;
	logic [1:0] pwm_reg;
	logic gate;
	logic psg_reg;

	always_comb
	begin
		if (alarm)
			mix = en1 && first_channel_output_reg && envelope;
		else
			mix = (en1 && first_channel_output_reg) || (en2 && second_channel_output);
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			pwm_reg <= 2'h0;
		else if (tone_tick)
			pwm_reg <= pwm_reg + 2'h1;
	end

	// The undivided LF source (00) cannot chop fast enough, so volume is bypassed there; LF/2 keeps it
	assign gate = (mode_reg.clk_sel == `TSG_SRC_LF) || (pwm_reg <= ctl_reg.vol);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			psg_reg <= 1'b0;
		else
			psg_reg <= mix && gate;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			pins <= 4'h0;
		else
		begin
			pins.port_a_bit1_sel <= port_mode_control_reg.sound_pin_route;
			pins.port_a_bit1_out <= port_mode_control_reg.sound_pin_route && psg_reg;
			pins.port_a_bit2_sel <= port_mode_control_reg.inverted_sound_pin_route;
			pins.port_a_bit2_out <= port_mode_control_reg.inverted_sound_pin_route && !psg_reg;
		end
	end

	//==========================================
	// Assertions
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	pin_route_a: assert property ((sys_wr && sys_addr == `TSG_A_PORT_MODE_CONTROL && sys_wdata[1]) ##1 !sys_wr
		|=> pins.port_a_bit1_sel) else $error("route bit not applied");
	inv_pin_a: assert property (pins.port_a_bit1_sel && pins.port_a_bit2_sel
		|-> pins.port_a_bit1_out != pins.port_a_bit2_out) else $error("pins not inverse");
	idle_quiet_a: assert property ((!en1 && !en2) [*3]
		|-> !pins.port_a_bit1_out) else $error("sound while disabled");
	ch1_hold_a: assert property (!en1 |=> $stable(ch1_lfsr_reg))
		else $error("channel one ran while disabled");
	ch1_reload_a: assert property (ch1_tick && ch1_lfsr_reg == `TSG_CODE_LAST
		|=> ch1_lfsr_reg == $past(code1_reg) && first_channel_output_reg != $past(first_channel_output_reg))
		else $error("divider reload wrong");
	ch1_step_a: assert property (ch1_tick && ch1_lfsr_reg != `TSG_CODE_LAST
		&& ch1_lfsr_reg != 7'h00 |=> ch1_lfsr_reg == step7($past(ch1_lfsr_reg)))
		else $error("divider step wrong");
	oct_scale_a: assert property (ch1_tick && first_channel_octave_reg |-> pre1_reg == 3'h7)
		else $error("octave scale wrong");
	src_hf16_a: assert property (tone_tick && mode_reg.clk_sel == `TSG_SRC_HF16
		|-> hf_edge && hf_cnt_reg == 4'hf) else $error("tone clock source wrong");
	vol_force_a: assert property (mode_reg.clk_sel == `TSG_SRC_LF |-> gate)
		else $error("volume not forced");
	vol_low_a: assert property (mode_reg.clk_sel != `TSG_SRC_LF && ctl_reg.vol == 2'h0
		&& pwm_reg != 2'h0 |-> !gate) else $error("volume level wrong");
	ch2_hold_a: assert property (!en2 |=> $stable(noise_reg) && $stable(ch2_lfsr_reg))
		else $error("channel two ran while disabled");
	alarm_dc_a: assert property (alarm && code2_reg[3:0] == 4'h0
		|-> mix == (en1 && first_channel_output_reg)) else $error("alarm envelope wrong");
	mix_ch2_a: assert property (!alarm && en2 && !en1 |-> mix == second_channel_output)
		else $error("mixer wrong");

	tone_c: cover property (ch1_tick && ch1_lfsr_reg == `TSG_CODE_LAST);
	noise_c: cover property (ch2_tick && mode_reg.noise_function_bit);
	alarm_c: cover property (alarm && en1 && pins.port_a_bit1_out);
	both_c: cover property (en1 && en2 && pins.port_a_bit2_sel && pins.port_a_bit1_sel);

endmodule

// [logic/tsg_defines.svh]
`ifndef TSG_DEFINES_SVH
`define TSG_DEFINES_SVH
// System register addresses
`define TSG_A_PORT_MODE_CONTROL 5'h13
`define TSG_A_C1L 5'h17
`define TSG_A_C1H 5'h18
`define TSG_A_C2N1 5'h19
`define TSG_A_C2N2 5'h1a
`define TSG_A_C2N3 5'h1b
`define TSG_A_C2N4 5'h1c
`define TSG_A_CTL 5'h1d
`define TSG_A_MODE 5'h1e
// Reset values
`define TSG_RST_NIB 4'h0
`define TSG_RST_CODE 7'h00
`define TSG_NOISE_SEED 15'h0001
// Divider and clock selection
`define TSG_CODE_LAST 7'h40
`define TSG_OCT_LAST 3'h7
`define TSG_HF_LAST 4'hf
`define TSG_SRC_LF 2'h0
`define TSG_SRC_LF2 2'h1
`define TSG_SRC_HF 2'h2
`define TSG_SRC_HF16 2'h3
// Envelope bit positions in the slow counter
`define TSG_ENV_1HZ 14
`define TSG_ENV_4HZ 12
`define TSG_ENV_8HZ 11
`define TSG_ENV_32HZ 9
`endif

// [logic/tsg_pkg.sv]
package tsg_pkg;
	// Register at $1e
	typedef struct packed
	{
		logic [1:0] clk_sel;
		logic noise_function_bit;
		logic alarm_function_bit;
	} tsg_mode_t;
	// Register at $1d
	typedef struct packed
	{
		logic [1:0] vol;
		logic second_channel_enable;
		logic first_channel_enable;
	} tsg_ctl_t;
	// Register at $13
	typedef struct packed
	{
		logic pull_up;
		logic inverted_sound_pin_route;
		logic sound_pin_route;
		logic heavy_load;
	} tsg_port_mode_control_t;
	// Shared port A pins
	typedef struct packed
	{
		logic port_a_bit1_sel;
		logic port_a_bit1_out;
		logic port_a_bit2_sel;
		logic port_a_bit2_out;
	} tsg_pins_t;
endpackage

// [tb/tsg_speaker.sv]
module tsg_speaker
(
	// Clock and window control
	input wire logic mclk,
	input wire logic clr,
	// Pin under the cone
	input wire logic cone
);
	timeunit 1ns;
	timeprecision 1ns;
	int per;
	int hi;
	int edges;
	int cnt;
	logic last;
	// ============================================================
	// Passive listener
	// A cone only listens; it never loads the pin, so no drive here
	always @(posedge mclk)
	begin
		last <= cone;
		cnt <= cnt + 1;
		if (clr)
		begin
			edges <= 0;
			hi <= 0;
			per <= 0;
		end
		else
		begin
			hi <= hi + int'(cone === 1'b1);
			if (cone === 1'b1 && last === 1'b0)
			begin
				edges <= edges + 1;
				per <= cnt;
				cnt <= 1;
			end
		end
	end
endmodule

// [tb/tsg_sound_tb.sv]
`include "tsg_defines.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tsg_sound_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0;
	logic nrst = 0;
	logic lf = 0;
	logic hf = 0;
	logic [4:0] sys_addr = 0;
	logic sys_wr = 0;
	logic sys_rd = 0;
	logic [3:0] sys_wdata = 0;
	logic [3:0] sys_rdata;
	logic clr = 0;
	logic [3:0] r1;
	logic [3:0] r2;
	tsg_pkg::tsg_pins_t pins;
	tsg_pkg::tsg_port_mode_control_t port_mode;
	int bad_count = 0;
	int num_checks = 0;
	int p;
	int k;
	logic [6:0] codes [6] = '{7'h40, 7'h60, 7'h70, 7'h78, 7'h7c, 7'h7e};
	// ============================================================
	// Clocks: oscillator edges land on falling mclk edges only
	always #10 mclk = ~mclk;
	always #200 lf = ~lf;
	always #80 hf = ~hf;
	tsg_sound uut
	(
		.mclk(mclk), .nrst(nrst), .low_frequency_source(lf), .high_frequency_source(hf),
		.sys_addr(sys_addr), .sys_wr(sys_wr), .sys_rd(sys_rd), .sys_wdata(sys_wdata),
		.sys_rdata(sys_rdata), .pins(pins), .port_mode(port_mode)
	);
	tsg_speaker spk
	(
		.mclk(mclk), .clr(clr), .cone(pins.port_a_bit1_out)
	);
	// ============================================================
	// Bus tasks
	task automatic wr(input logic [4:0] a, input logic [3:0] d);
		sys_addr <= a;
		sys_wdata <= d;
		sys_wr <= 1'b1;
		@(posedge mclk);
		sys_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [4:0] a, output logic [3:0] d);
		sys_addr <= a;
		sys_rd <= 1'b1;
		@(posedge mclk);
		sys_rd <= 1'b0;
		@(posedge mclk);
		d = sys_rdata;
	endtask
	task automatic tone(input logic [1:0] src, input logic oct, input logic [6:0] c,
		input logic [1:0] md, input logic [1:0] vol, input logic ch2);
		// Channels off while the nibbles change, so no half-written code is loaded
		wr(`TSG_A_CTL, 4'h0);
		wr(ch2 ? `TSG_A_C2N3 : `TSG_A_C1L, c[3:0]);
		wr(ch2 ? `TSG_A_C2N4 : `TSG_A_C1H, {oct, c[6:4]});
		wr(`TSG_A_MODE, {src, md});
		// One channel at a time, so the two never share a tone
		wr(`TSG_A_CTL, {vol, ch2, ~ch2});
	endtask
	task automatic measure(input int cyc);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		repeat (cyc) @(posedge mclk);
	endtask
	function automatic int exp_per(input logic [1:0] src, input logic oct, input int n);
		int d;
		d = (src == 2'h0) ? 20 : (src == 2'h1) ? 40 : (src == 2'h2) ? 8 : 128;
		return 2 * n * d * (oct ? 8 : 1);
	endfunction
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ============================================================
	// Main sequence
	initial
	begin
		void'($urandom(99));
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		`CHK(pins, 4'h0);
		`CHK(port_mode, 4'h0);
		rd(`TSG_A_C2N1, r1);
		`CHK(r1, 4'h0);
		for (k = 0; k < 4; k++)
		begin
			r2 = 4'($urandom);
			wr(`TSG_A_PORT_MODE_CONTROL, r2);
			rd(`TSG_A_PORT_MODE_CONTROL, r1);
			`CHK(r1, r2);
			`CHK(port_mode, r2);
			`CHK({pins.port_a_bit1_sel, pins.port_a_bit2_sel}, {r2[1], r2[2]});
		end
		rd(5'h1f, r1);
		`CHK(r1, 4'h0);
		wr(`TSG_A_PORT_MODE_CONTROL, 4'h6);
		// Divider codes across all sources, either channel
		for (k = 0; k < 8; k++)
		begin
			r2 = 4'($urandom % 6);
			r1 = 4'($urandom);
			tone(r1[1:0], 1'b0, codes[r2], 2'b00, 2'h3, r1[2]);
			p = exp_per(r1[1:0], 1'b0, int'(r2) + 1);
			// Margin lets the old divider chain run out before two full periods
			measure(3 * p + 900);
			`CHK(spk.per, p);
			`CHK(pins.port_a_bit2_out, ~pins.port_a_bit1_out);
		end
		tone(2'h2, 1'b0, 7'h01, 2'b00, 2'h3, 1'b0);
		measure(3 * 2032 + 100);
		`CHK(spk.per, 2032);
		// Walk channel one out of the long chain before the short tests
		tone(2'h2, 1'b0, 7'h40, 2'b00, 2'h3, 1'b0);
		repeat (1100) @(posedge mclk);
		tone(2'h2, 1'b1, 7'h40, 2'b00, 2'h3, 1'b1);
		measure(1000);
		`CHK(spk.per, 128);
		tone(2'h2, 1'b1, 7'h40, 2'b00, 2'h3, 1'b0);
		measure(500);
		`CHK(spk.per, 128);
		// Infrared carrier setup: code 78, undivided HF
		tone(2'h2, 1'b0, 7'h78, 2'b00, 2'h3, 1'b0);
		repeat (64) @(posedge mclk);
		for (k = 0; k < 4; k++)
		begin
			wr(`TSG_A_CTL, {2'(k), 2'b01});
			wr(`TSG_A_C1L, 4'h8);
			measure(640);
			`CHK(spk.hi >= 80 * (k + 1) - 8 && spk.hi <= 80 * (k + 1) + 8, 1'b1);
		end
		tone(2'h0, 1'b0, 7'h78, 2'b00, 2'h0, 1'b0);
		measure(1600);
		`CHK(spk.hi >= 780 && spk.hi <= 820, 1'b1);
		tone(2'h2, 1'b0, 7'h40, 2'b10, 2'h3, 1'b1);
		measure(2000);
		`CHK(spk.edges > 0, 1'b1);
		tone(2'h2, 1'b0, 7'h40, 2'b01, 2'h3, 1'b0);
		wr(`TSG_A_CTL, 4'hf);
		measure(200);
		`CHK(spk.per, 16);
		wr(`TSG_A_C2N1, 4'h8);
		rd(`TSG_A_C2N1, r1);
		repeat (10238) @(posedge mclk);
		rd(`TSG_A_C2N1, r2);
		`CHK(r1[3] ^ r2[3], 1'b1);
		wr(`TSG_A_MODE, 4'h8);
		rd(`TSG_A_C2N1, r1);
		`CHK(r1, 4'h0);
		wr(`TSG_A_CTL, 4'hc);
		measure(500);
		`CHK(spk.edges, 0);
		`CHK({pins.port_a_bit1_out, pins.port_a_bit2_out}, 2'b01);
		nrst <= 1'b0;
		@(posedge mclk);
		`CHK(pins, 4'h0);
		`CHK(port_mode, 4'h0);
		nrst <= 1'b1;
		report_and_stop();
	end
endmodule
